/* File: common/fco_regs.vh */
// Register indices, field positions and reset values for the flash
// control and RAM overlay block. Definitions only; included by name.
`ifndef FCO_REGS_VH
`define FCO_REGS_VH
// Register indices (byte address on the bus is four times the index)
`define FCO_IDX_CTRL1 16'hff40
`define FCO_IDX_CTRL2 16'hff41
`define FCO_IDX_EBSEL 16'hff42
`define FCO_IDX_OVRAM 16'hff47
// Reset values and erased word value
`define FCO_RST_CTRL 8'h00
`define FCO_RST_OVRAM 8'hf0
`define FCO_ERASED 32'hffffffff
// Control one fields
`define FCO_C1_GUARD 7
`define FCO_C1_SWE 6
`define FCO_C1_ESU 5
`define FCO_C1_PSU 4
`define FCO_C1_EV 3
`define FCO_C1_PV 2
`define FCO_C1_E 1
`define FCO_C1_P 0
// Overlay control fields: select bit, emulation block in low two bits
`define FCO_OV_SEL 3
`define FCO_OV_HI 4'hf
// Region decode on haddr[17:10]
`define FCO_OVR_REGION 8'h80
// Erase block bounds in words, block 0 lowest, nine edges
`define FCO_BLK_BOUNDS {16'h8000, 16'h6000, 16'h4000, 16'h2000, \
    16'h0400, 16'h0300, 16'h0200, 16'h0100, 16'h0000}
`define FCO_NBLK 8
`endif

/* File: hdl/fco_top.v */
// Flash control registers, erase sequencer and RAM overlay read path.
// Assumes one AHB-Lite master, one clock, and pins from outside.
//
// Behaviour
// - Erase sets every word of block to ones
// - Emulated block reads come from overlay RAM
// - Clearing select bit restores flash reads
// - Eight erase blocks: 3x32K, 28K, 4x1K
// - Guard pin low blocks program and erase
// - Registers at ff40, ff41, ff42, ff47
// - Flash disabled: control regs read zero
// - Control writes ignored while guard bit zero
// - Control one top bit follows guard pin
// - Erase select held zero without enables
// - Control registers are byte wide
// - Control two low bits store and read
// - Control one bits gated by prerequisites
// - Control one bit seven reads pin level
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "fco_regs.vh"

module fco_top #(
    parameter AW = 15,
    parameter OW = 8
) (
    input wire clock,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire flash_write_guard,
    input wire op_mode_pin_hi,
    input wire op_mode_pin_mid,
    input wire op_mode_pin_lo,
    output reg erase_busy
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    reg [3:0] pin_meta; // First stage, read only by second
    reg [3:0] pin_sync; // Guard, mode hi, mid, lo

    // Two flops for every pin from outside
    always @(posedge clock) begin
        if (reset) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {flash_write_guard, op_mode_pin_hi,
                op_mode_pin_mid, op_mode_pin_lo};
            pin_sync <= pin_meta;
        end
    end

    wire guard = pin_sync[3];
    // Flash on in modes 5 to 7 only; mode 4 has it off
    wire flash_on = pin_sync[2] & (pin_sync[1] | pin_sync[0]);

    // ==========================================================
    // Storage
    // ==========================================================
    reg [31:0] flash_mem [0:(1<<AW)-1]; // Flash array words
    reg [31:0] ovl_mem [0:(1<<OW)-1]; // Overlap RAM words
    reg [6:0] ctrl1_low; // Control one bits 6..0
    localparam [7:0] RST_C = `FCO_RST_CTRL; // Control group reset
    localparam [7:0] RST_OV = `FCO_RST_OVRAM; // Overlay reset value
    reg [6:0] ctrl2_low; // Control two stored bits
    reg [7:0] ebsel; // Erase block select
    reg [3:0] ovram_low; // Overlay control low nibble

    // ==========================================================
    // Bus slave front end
    // ==========================================================
    reg pend; // Data phase outstanding
    reg pend_wr; // Outstanding one is a write
    reg [17:0] pend_addr; // Byte address of data phase
    reg rd_done; // Read data already loaded
    wire accept = hsel & htrans[1] & hready;

    wire [15:0] reg_idx = pend_addr[17:2];
    wire in_flash = ~pend_addr[17];
    wire in_ovl = pend_addr[17:10] == `FCO_OVR_REGION;
    wire [AW-1:0] fword = pend_addr[AW+1:2];
    wire [OW-1:0] oword = pend_addr[OW+1:2];

    // Flash accesses wait while the erase walk owns the array
    wire stall = erase_busy & in_flash;
    // Reads take one extra cycle so data comes from a flop
    assign hreadyout = ~pend | (~stall & (pend_wr | rd_done));
    assign hresp = 1'b0; // Always OKAY, unmapped included

    // Address phase capture and data phase retire
    always @(posedge clock) begin
        if (reset) begin
            pend <= 1'b0;
            pend_wr <= 1'b0;
            pend_addr <= 18'h0;
        end else if (accept) begin
            pend <= 1'b1;
            pend_wr <= hwrite;
            pend_addr <= haddr[17:0];
        end else if (hreadyout) begin
            pend <= 1'b0;
        end
    end

    wire wr_now = pend & pend_wr & hreadyout; // Write data valid
    wire rd_now = pend & ~pend_wr & ~rd_done & ~stall;

    // ==========================================================
    // Register views
    // ==========================================================
    // Bit seven is the live pin level, never stored
    wire [7:0] ctrl1 = {guard, ctrl1_low[6:0]};
    wire soft_program_permit = ctrl1_low[`FCO_C1_SWE];
    wire [7:0] ovram = {`FCO_OV_HI, ovram_low};
    // Control group writable only with flash on and guard bit set
    wire ctl_we = wr_now & flash_on & guard;
    wire [7:0] wd = hwdata[7:0]; // Byte data sits in low lane

    // ==========================================================
    // Control one, two and erase select
    // ==========================================================
    always @(posedge clock) begin
        if (reset) begin
            ctrl1_low <= RST_C[6:0];
            ctrl2_low <= 7'h00;
            ebsel <= `FCO_RST_CTRL;
        end else begin
            if (~guard) begin
                // Hardware protect drops all operation bits
                ctrl1_low <= RST_C[6:0];
            end else if (ctl_we && reg_idx == `FCO_IDX_CTRL1) begin
                // Each bit only with its prerequisites met
                ctrl1_low[`FCO_C1_SWE] <= wd[`FCO_C1_SWE];
                if (soft_program_permit) begin
                    ctrl1_low[5:2] <= wd[5:2];
                    if (ctrl1_low[`FCO_C1_ESU]) begin
                        ctrl1_low[`FCO_C1_E] <= wd[`FCO_C1_E];
                    end
                    if (ctrl1_low[`FCO_C1_PSU]) begin
                        ctrl1_low[`FCO_C1_P] <= wd[`FCO_C1_P];
                    end
                end
            end
            if (ctl_we && reg_idx == `FCO_IDX_CTRL2) begin
                ctrl2_low <= wd[6:0];
            end
            if (~guard | ~soft_program_permit) begin
                ebsel <= `FCO_RST_CTRL;
            end else if (ctl_we && reg_idx == `FCO_IDX_EBSEL) begin
                ebsel <= wd;
            end
        end
    end

    // Overlay control is writable in any mode
    always @(posedge clock) begin
        if (reset) begin
            ovram_low <= RST_OV[3:0];
        end else if (wr_now && reg_idx == `FCO_IDX_OVRAM) begin
            ovram_low <= wd[3:0];
        end
    end

    // ==========================================================
    // Erase block membership of the walk counter
    // ==========================================================
    localparam [16*(`FCO_NBLK+1)-1:0] BOUNDS = `FCO_BLK_BOUNDS;
    reg [AW-1:0] walk; // Word being erased
    wire [`FCO_NBLK-1:0] in_blk; // Walk word inside block i

    genvar gi;
    generate
        for (gi = 0; gi < `FCO_NBLK; gi = gi + 1) begin : g_blk
            // Unequal block sizes come from the edge table
            assign in_blk[gi] =
                ({1'b0, walk} >= BOUNDS[16*gi +: 16]) &&
                ({1'b0, walk} < BOUNDS[16*(gi+1) +: 16]);
        end
    endgenerate

    wire walk_hit = |(in_blk & ebsel);

    // ==========================================================
    // Erase sequencer
    // ==========================================================
    localparam ST_IDLE = 1'b0;
    localparam ST_WALK = 1'b1;
    reg state; // Sequencer state
    reg next_state; // Its next value
    reg e_prev; // Erase bit one cycle ago
    wire e_bit = ctrl1_low[`FCO_C1_E];
    wire e_start = e_bit & ~e_prev & guard & soft_program_permit;
    wire walk_end = &walk;

    // Next state
    always @* begin
        case (state)
            ST_IDLE: next_state = e_start ? ST_WALK : ST_IDLE;
            // Losing the guard or enable aborts the walk
            ST_WALK: next_state = (walk_end | ~guard | ~soft_program_permit) ?
                ST_IDLE : ST_WALK;
            default: next_state = ST_IDLE;
        endcase
    end

    // State, walk counter and busy flag
    always @(posedge clock) begin
        if (reset) begin
            state <= ST_IDLE;
            e_prev <= 1'b0;
            walk <= {AW{1'b0}};
            erase_busy <= 1'b0;
        end else begin
            state <= next_state;
            e_prev <= e_bit;
            erase_busy <= next_state == ST_WALK;
            if (state == ST_WALK) begin
                walk <= walk + 1'b1;
            end else begin
                walk <= {AW{1'b0}};
            end
        end
    end

    // ==========================================================
    // Array writes
    // ==========================================================
    // Programming only clears bits, so an unerased word cannot gain
    // ones; the erased-first order stays software's job.
    wire prog_ok = guard & soft_program_permit & ctrl1_low[`FCO_C1_P];
    wire [31:0] old_word = flash_mem[fword];

    always @(posedge clock) begin
        if (state == ST_WALK && walk_hit && guard) begin
            flash_mem[walk] <= `FCO_ERASED;
        end else if (wr_now && in_flash && prog_ok) begin
            flash_mem[fword] <= old_word & hwdata;
        end
    end

    // Overlap RAM is plain RAM on the bus
    always @(posedge clock) begin
        if (wr_now && in_ovl) begin
            ovl_mem[oword] <= hwdata;
        end
    end

    // ==========================================================
    // Overlay redirection and read data
    // ==========================================================
    wire ov_on = ovram_low[`FCO_OV_SEL];
    // Emulated 1K block starts at word 256*block, one of the four small ones
    wire [1:0] ov_blk = ovram_low[1:0];
    wire ov_hit = ov_on &&
        fword[AW-1:OW+2] == {(AW-OW-2){1'b0}} &&
        fword[OW+1:OW] == ov_blk;
    wire [OW-1:0] ov_word = fword[OW-1:0];

    reg [31:0] rd_mux; // Read value for the pending address

    // Read multiplexer
    always @* begin
        rd_mux = 32'h0;
        if (in_flash) begin
            rd_mux = ov_hit ? ovl_mem[ov_word] : old_word;
        end else if (in_ovl) begin
            rd_mux = ovl_mem[oword];
        end else begin
            case (reg_idx)
                `FCO_IDX_CTRL1: rd_mux[7:0] = flash_on ? ctrl1 : 8'h00;
                `FCO_IDX_CTRL2:
                    rd_mux[7:0] = flash_on ? {1'b0, ctrl2_low} : 8'h00;
                `FCO_IDX_EBSEL: rd_mux[7:0] = flash_on ? ebsel : 8'h00;
                `FCO_IDX_OVRAM: rd_mux[7:0] = ovram;
                default: rd_mux = 32'h0; // Unused slots read zero
            endcase
        end
    end

    // Read data flop and its one-shot loaded flag
    always @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h0;
            rd_done <= 1'b0;
        end else begin
            if (rd_now) begin
                hrdata <= rd_mux;
            end
            rd_done <= rd_now | (rd_done & ~hreadyout);
        end
    end

endmodule
`default_nettype wire

/* File: test/fco_chk.sv */
// Checker for the flash control block, bound to its top ports.
// Assumes the bus hready is looped back from hreadyout.
`timescale 1ns/10ps
`default_nettype none
module fco_chk #(parameter AW = 15, parameter OW = 8) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic flash_write_guard,
    input wire logic op_mode_pin_hi,
    input wire logic op_mode_pin_mid,
    input wire logic op_mode_pin_lo,
    input wire logic erase_busy
);
    // ==========
    // Decode helpers
    wire tk = hsel & htrans[1] & hready; // Request taken
    wire rd = tk & !hwrite & (haddr[17:10] == 8'hff); // Register read
    wire rd1 = rd & (haddr[7:0] == 8'h00); // Control one read
    wire off = !(op_mode_pin_hi & (op_mode_pin_mid | op_mode_pin_lo));
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Pins pass two synchronising flops, hence the repeats of four, and of five for the registered busy flag
    reg_rd_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("register read wait wrong");
    reg_wr_fast_a: assert property (
        tk & hwrite & haddr[17:10] == 8'hff |=> hreadyout)
        else $error("register write stalled");
    byte_wide_a: assert property (rd |=> ##1 hrdata[31:8] == 24'h0)
        else $error("register upper bits set");
    off_zero_a: assert property (
        off [*4] ##0 (rd & haddr[7:0] < 8'h0c) |=> ##1 hrdata == 32'h0)
        else $error("flash off read not zero");
    guard_low_a: assert property (
        (!flash_write_guard) [*4] ##0 rd1 |=> ##1 hrdata[7:0] == 8'h00)
        else $error("control one not zero");
    guard_high_a: assert property (
        (flash_write_guard & !off) [*4] ##0 rd1 |=> ##1 hrdata[7])
        else $error("control one top bit low");
    ov_top_a: assert property (rd & haddr[7:0] == 8'h1c
        |=> ##1 hrdata[7:4] == 4'hf) else $error("overlay top bits wrong");
    busy_guard_a: assert property (
        (!flash_write_guard) [*5] |-> !erase_busy)
        else $error("erase runs with guard low");
    // Unmapped slots included, the slave never signals an error
    resp_okay_a: assert property (!hresp)
        else $error("slave response not okay");
    cover property ($rose(erase_busy));
    cover property (rd1 & !flash_write_guard);
    cover property (rd & off);
endmodule
`default_nettype wire

/* File: test/fco_cpu.sv */
// Bus master model standing for the processor on the register bus.
// Assumes hready is the slave's hreadyout; single word transfers only.
`timescale 1ns/10ps
`default_nettype none
module fco_cpu (
    input wire logic clock,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic rd_done,
    output logic [31:0] rd_val
);
    // ==========
    // Idle bus at time zero
    initial begin
        {hsel, htrans, hwrite, haddr, hwdata, rd_done, rd_val} = '0;
        hsize = 3'h2; // Whole words only
    end
    // Read result stands one cycle
    always @(posedge clock) begin
        if (rd_done) rd_done <= 1'b0;
    end
    // One transfer; released lines show the inverse, not a stale value
    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(posedge clock);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
        do @(posedge clock); while (hready !== 1'b1);
        {hsel, htrans, haddr, hwdata} <= {1'b0, 2'h0, ~a, d};
        do @(posedge clock); while (hready !== 1'b1);
        hwdata <= ~d;
        if (!w) {rd_val, rd_done} <= {hrdata, 1'b1};
    endtask
endmodule
`default_nettype wire

/* File: test/fco_top_tb.sv */
// Self-checking bench for the flash control block.
// Assumes the bus master model drives the bus; expectations queue up.
`timescale 1ns/10ps
`default_nettype none
`include "fco_regs.vh"
module fco_top_tb;
    // ==========
    // Stimulus and observation
    localparam logic [31:0] C1 = `FCO_IDX_CTRL1 * 4;
    localparam logic [31:0] C2 = `FCO_IDX_CTRL2 * 4;
    localparam logic [31:0] EB = `FCO_IDX_EBSEL * 4;
    localparam logic [31:0] OV = `FCO_IDX_OVRAM * 4;
    localparam logic [31:0] FF = `FCO_ERASED;
    logic clock = 0, reset = 1, g = 1, mh = 1, mm = 1, ml = 1;
    wire hsel, hwrite, hreadyout, hresp, erase_busy, rd_done;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] haddr, hwdata, hrdata, rd_val;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    logic [31:0] exp_q[$];
    logic [31:0] p, q, r;
    always #12.5 clock = ~clock;
    fco_top dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .flash_write_guard(g), .op_mode_pin_hi(mh),
        .op_mode_pin_mid(mm), .op_mode_pin_lo(ml), .erase_busy(erase_busy));
    fco_cpu cpu (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .rd_done(rd_done), .rd_val(rd_val));
    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        cpu.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, e);
        exp_q.push_back(e);
        cpu.xfer(1'b0, a, 32'h0);
    endtask
    // Pins move, then settle past the synchronisers
    task automatic pins(input logic gv, input logic [2:0] m);
        @(posedge clock);
        {g, mh, mm, ml} <= {gv, m};
        repeat (4) @(posedge clock);
    endtask
    task automatic final_report();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Oldest expectation against each read result
    always @(posedge clock) begin
        if (rd_done === 1'b1) check(rd_val, exp_q.pop_front());
    end
    // Two full erase walks dominate the run time
    always @(posedge clock) begin
        cyc++;
        if (cyc > 90000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'hc86b));
        {p, q, r} = {$urandom, $urandom, $urandom};
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd(C1, 32'h80); rd(C2, 0);
        rd(EB, 0); rd(OV, 32'hf0);
        rd(OV, 32'hf0); // Second read leaves overlay control unchanged
        for (int m = 1; m < 8; m++) begin
            pins(1'b1, m[2:0]);
            rd(C1, m > 4 ? 32'h80 : 0);
            wr(C2, r);
            rd(C2, m > 4 ? {25'h0, r[6:0]} : 0);
        end
        pins(1'b1, 3'h1); wr(C2, ~r); pins(1'b1, 3'h7);
        rd(C2, {25'h0, r[6:0]});
        wr(C1, 32'h3f); rd(C1, 32'h80);
        wr(C1, 32'h40); wr(C1, 32'h4f); rd(C1, 32'hcc);
        wr(EB, r); rd(EB, {24'h0, r[7:0]});
        wr(C1, 0); rd(EB, 0);
        pins(1'b0, 3'h7); wr(C1, 32'h40); wr(C2, ~r); rd(C1, 0);
        rd(C2, {25'h0, r[6:0]}); pins(1'b1, 3'h7);
        wr(C1, 32'h40); wr(EB, 32'hff); wr(C1, 32'h60); wr(C1, 32'h62);
        repeat (2) @(posedge clock);
        check(erase_busy, 1);
        rd(C1, 32'he2); rd(32'h3fc, FF);
        check(erase_busy, 0);
        wr(C1, 32'h40);
        wr(C1, 32'h50); wr(C1, 32'h51); // Erased blocks only
        wr(32'h3fc, p); wr(32'h400, p); wr(32'h800, p); rd(32'h3fc, p);
        wr(C1, 0); pins(1'b0, 3'h7); // Bits cleared first
        wr(C1, 32'h40); wr(C1, 32'h50); wr(C1, 32'h51); wr(32'h3fc, 0);
        pins(1'b1, 3'h7); rd(32'h3fc, p);
        wr(C1, 32'h40); wr(EB, 32'h02); wr(C1, 32'h60); wr(C1, 32'h62);
        rd(32'h400, FF); rd(32'h3fc, p); rd(32'h800, p);
        wr(C1, 32'h40); wr(C1, 0);
        // User mode overlay on block one
        // Only emulated data is ever put into overlap RAM
        wr(32'h20000, q); wr(OV, 32'h09); rd(OV, 32'hf9);
        rd(32'h400, q); rd(32'h3fc, p);
        wr(OV, 32'h01); rd(32'h400, FF);
        repeat (4) @(posedge clock);
        final_report();
    end
endmodule
bind fco_top fco_chk #(.AW(AW), .OW(OW)) chk (.clock(clock), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .flash_write_guard(flash_write_guard), .op_mode_pin_hi(op_mode_pin_hi),
    .op_mode_pin_mid(op_mode_pin_mid), .op_mode_pin_lo(op_mode_pin_lo),
    .erase_busy(erase_busy));
`default_nettype wire
